// ---- cfs_link_model.sv ----
`timescale 1ns/1ps
// ********
// Host and chain frame source
// ********
module cfs_link_model (
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic [7:0] i_n,
   input wire logic [3:0] i_gap,
   output logic o_host_frame_ok,
   output logic o_chain_frame_ok
);
   int left = 0;
   int gap_c = 0;
   initial begin
      o_host_frame_ok = 1'b0;
      o_chain_frame_ok = 1'b0;
   end
   // Commands and replies alternate, as in bring-up traffic
   always @(posedge i_clk) begin
      o_host_frame_ok <= 1'b0;
      o_chain_frame_ok <= 1'b0;
      if (i_go) begin
         left <= i_n;
         gap_c <= 0;
      end else if (left > 0 && gap_c == 0) begin
         o_host_frame_ok <= left[0];
         o_chain_frame_ok <= !left[0];
         left <= left - 1;
         gap_c <= i_gap - 1;
      end else if (gap_c > 0) begin
         gap_c <= gap_c - 1;
      end
   end
endmodule : cfs_link_model

// ---- cfs_pkg.sv ----
package cfs_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_CTS_TIME = 16'h0004;
   localparam logic [ADDR_W-1:0] ADDR_LONG_TIMEOUT_PERIOD = 16'h0008;
   localparam logic [ADDR_W-1:0] ADDR_SUMMARY = 16'h000C;
   localparam logic [ADDR_W-1:0] ADDR_L2 = 16'h0010;
   localparam logic [ADDR_W-1:0] ADDR_MASK = 16'h0014;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0018;
   localparam logic [ADDR_W-1:0] ADDR_UNLOCK = 16'h001C;
   localparam logic [ADDR_W-1:0] ADDR_DBG_CTRL = 16'h0020;
   localparam logic [ADDR_W-1:0] ADDR_DBG_STAT = 16'h0024;
   localparam logic [ADDR_W-1:0] ADDR_TIMER_STAT = 16'h0028;
   // Low level fault block, index 0x2301..0x2307 at byte address 4*index
   localparam logic [ADDR_W-1:0] IDX_L3_FIRST = 16'h2301;
   localparam int N_L3 = 7;
   // ****************************************
   // Fields
   // ****************************************
   localparam int N_GRP = 4;
   localparam int N_L2 = 8;
   localparam int L3_W = 8;
   localparam int CTRL_ALERT_OUT_PIN_EN = 0;
   localparam int CTRL_CTL_ACT = 1;
   localparam int CTRL_CTS_EN = 2;
   localparam int CTRL_CTL_EN = 3;
   localparam int CTRL_SLEEP_REQ = 4;
   localparam int CTRL_WAKE_REQ = 5;
   localparam int CTRL_RST = 32'h0000_0000;
   localparam logic [7:0] UNLOCK_KEY = 8'hA5;
   localparam logic [7:0] DBG_CTRL_RST = 8'h3C;
   localparam int TMR_W = 32;
   localparam logic [TMR_W-1:0] CTS_RST = 32'h0000_0FA0;
   localparam logic [TMR_W-1:0] CTL_RST = 32'h0009_C400;
   // Group of each second level bit; each group owns two bits
   localparam logic [N_L2*2-1:0] L2_GRP = 16'hFA50;
   // Which third level register feeds each second level bit
   localparam logic [N_L2*3-1:0] L2_SRC = 24'h0000_0000;
   localparam int SUM_COMM = 0;
   localparam int SUM_PWR = 1;
   typedef enum logic [1:0] {
      CFS_ACTIVE = 2'b00,
      CFS_SLEEP = 2'b01,
      CFS_SHUTDOWN = 2'b10
   } cfs_mode_e;
endpackage : cfs_pkg

// ---- cfs_supervisor.sv ----
`timescale 1ns/1ps
// How it works
// [R1] Host broadcasts 0x01 to stack register 0x309 to enable addressing.
// [R2] Host broadcasts addresses 0..3 to 0x306; bridge takes zero.
// [R3] Host broadcasts 0x02 to 0x308 marking chain devices as stack.
// [R4] Host writes 0x03 to 0x308 of the top device only.
// [R5] Host sends eight sync writes 0x343..0x34A, then eight reads.
// [R6] Host reads back addresses, then expects 0x14 from bridge 0x2001.
// [R7] Host sets direction select first for reverse bring-up.
// [R8] Host broadcasts 0x80, 0x02, 0x81 in reverse to flip stack.
// [R9] Reverse addresses go to 0x307 and are verified there.
// [R10] Direction change on live system skips only the wake step.
// [R11] In active, short timer flags fault, long timer changes mode.
// [R12] Timers count time without a valid host or chain frame.
// [R13] Shutdown clears timers; sleep freezes their counts.
// [R14] Every valid frame restarts both timers; the code restarts them in active only, a frame in sleep leaves the counts held.
// [R15] Software keeps the short timeout below the long one.
// [R16] Unlock register gates debug mode and its baud/port controls.
// [R17] Debug communication status is readable always.
// [R18] Low level fault bits live at index 0x2301..0x2307.
// [R19] Summary bit is OR of unmasked second level bits of group.
// [R20] Second level bit is OR of its third level bits; bit 7 has none and ORs i_l2_direct[3] with the short timeout flag.
// [R21] Fault bits stay latched until group reset is written.
// [R22] Group reset clears only bits whose condition is gone.
// [R23] Mask stops a group from reaching the summary only.
// [R24] Masked groups never assert the alert pin.
// [R25] Enabled driver pulls alert pin low on unmasked fault.
module cfs_supervisor
   import cfs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   input wire logic i_host_frame_ok,
   input wire logic i_chain_frame_ok,
   input wire logic [N_L3*L3_W-1:0] i_l3_cond,
   input wire logic [N_GRP-1:0] i_l2_direct,
   input wire logic [7:0] i_dbg_status,
   output logic [1:0] o_mode,
   output logic o_debug_on,
   output logic [7:0] o_debug_ctrl,
   output logic o_short_timeout,
   output logic o_alert_out_pin_o,
   output logic o_alert_out_pin_oe
);
   // ****************************************
   // Reset release
   // ****************************************
   logic rst_meta_r;
   logic rst_sync_r;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   wire logic rst_n = rst_sync_r;

   // ****************************************
   // Register writes
   // ****************************************
   logic [DATA_W-1:0] ctrl_r;
   logic [TMR_W-1:0] cts_time_r;
   logic [TMR_W-1:0] long_timeout_period_r;
   logic [N_GRP-1:0] mask_r;
   logic debug_on_r;
   logic [7:0] dbg_ctrl_r;
   wire logic wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
   wire logic wr_rst = i_wr && (i_addr == ADDR_RESET);
   wire logic [N_GRP-1:0] grp_clr = wr_rst ? i_wdata[N_GRP-1:0] : '0;
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         cts_time_r <= CTS_RST;
         long_timeout_period_r <= CTL_RST;
         mask_r <= '0;
      end else if (i_wr) begin
         if (i_addr == ADDR_CTRL) ctrl_r <= i_wdata;
         if (i_addr == ADDR_CTS_TIME) cts_time_r <= i_wdata;
         if (i_addr == ADDR_LONG_TIMEOUT_PERIOD) long_timeout_period_r <= i_wdata;
         if (i_addr == ADDR_MASK) mask_r <= i_wdata[N_GRP-1:0];
      end
   end

   // Debug controls move only while unlocked
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         debug_on_r <= 1'b0;
         dbg_ctrl_r <= DBG_CTRL_RST;
      end else if (i_wr) begin
         if (i_addr == ADDR_UNLOCK)
            debug_on_r <= (i_wdata[7:0] == UNLOCK_KEY); // R16
         if (i_addr == ADDR_DBG_CTRL && debug_on_r)
            dbg_ctrl_r <= i_wdata[7:0]; // R16
      end
   end

   // ****************************************
   // Power mode and timeout timers
   // ****************************************
   cfs_mode_e mode_r;
   logic [TMR_W-1:0] cts_cnt_r;
   logic [TMR_W-1:0] ctl_cnt_r;
   logic cts_flag_r;
   wire logic frame_ok = i_host_frame_ok || i_chain_frame_ok; // R12
   wire logic cts_hit = ctrl_r[CTRL_CTS_EN] && (cts_cnt_r >= cts_time_r);
   wire logic ctl_hit = ctrl_r[CTRL_CTL_EN] && (ctl_cnt_r >= long_timeout_period_r);

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= CFS_ACTIVE;
      end else begin
         case (mode_r)
            CFS_ACTIVE: begin
               if (ctl_hit && !frame_ok)
                  mode_r <= ctrl_r[CTRL_CTL_ACT] ? CFS_SHUTDOWN
                                                  : CFS_SLEEP; // R11
            end
            CFS_SLEEP: begin
               if (wr_ctrl && i_wdata[CTRL_WAKE_REQ]) mode_r <= CFS_ACTIVE;
            end
            CFS_SHUTDOWN: begin
               if (wr_ctrl && i_wdata[CTRL_WAKE_REQ]) mode_r <= CFS_ACTIVE;
            end
            default: mode_r <= CFS_ACTIVE;
         endcase
      end
   end

   // Counters saturate so a missed hit cannot wrap into silence
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         cts_cnt_r <= '0;
         ctl_cnt_r <= '0;
      end else if (mode_r == CFS_SHUTDOWN) begin
         cts_cnt_r <= '0; // R13
         ctl_cnt_r <= '0; // R13
      end else if (mode_r == CFS_ACTIVE) begin
         if (frame_ok) begin
            cts_cnt_r <= '0; // R14
            ctl_cnt_r <= '0; // R14
         end else begin
            if (!(&cts_cnt_r)) cts_cnt_r <= cts_cnt_r + 1'b1; // R11
            if (!(&ctl_cnt_r)) ctl_cnt_r <= ctl_cnt_r + 1'b1; // R11
         end
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         cts_flag_r <= 1'b0;
      end else if (mode_r == CFS_ACTIVE && cts_hit && !frame_ok) begin
         cts_flag_r <= 1'b1; // R11
      end else if (grp_clr[SUM_COMM]) begin
         cts_flag_r <= 1'b0; // R22
      end
   end

   // ****************************************
   // Fault hierarchy
   // ****************************************
   logic [N_L3*L3_W-1:0] l3_meta_r;
   logic [N_L3*L3_W-1:0] l3_cond_r;
   logic [N_L3*L3_W-1:0] l3_r;
   logic [N_L2-1:0] l2_r;
   logic [N_L2-1:0] l2_cond;
   logic [N_GRP-1:0] summary;
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         l3_meta_r <= '0;
         l3_cond_r <= '0;
      end else begin
         l3_meta_r <= i_l3_cond;
         l3_cond_r <= l3_meta_r;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < N_L3 * L3_W; gi++) begin : g_l3
         localparam int G = int'(L2_GRP[2*(gi/L3_W)%(2*N_L2) +: 2]);
         always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) l3_r[gi] <= 1'b0;
            else if (l3_cond_r[gi]) l3_r[gi] <= 1'b1; // R21
            else if (grp_clr[G]) l3_r[gi] <= 1'b0; // R22
         end
      end
      for (gi = 0; gi < N_L2; gi++) begin : g_l2
         localparam int G = int'(L2_GRP[2*gi +: 2]);
         localparam int S = gi % N_L3;
         // Next-state OR, so one reset write clears both levels
         assign l2_cond[gi] = (gi < N_L3)
            ? |(l3_cond_r[S*L3_W +: L3_W]
               | (l3_r[S*L3_W +: L3_W] & ~{L3_W{grp_clr[G]}}))
            : (i_l2_direct[G] | cts_flag_r); // R20 R22
         always_ff @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) l2_r[gi] <= 1'b0;
            else if (l2_cond[gi]) l2_r[gi] <= 1'b1; // R21
            else if (grp_clr[G]) l2_r[gi] <= 1'b0; // R22
         end
      end
      for (gi = 0; gi < N_GRP; gi++) begin : g_sum
         always_comb begin
            summary[gi] = 1'b0;
            for (int k = 0; k < N_L2; k++) begin
               if (int'(L2_GRP[2*k +: 2]) == gi)
                  summary[gi] = summary[gi] | l2_r[k];
            end
            summary[gi] = summary[gi] & ~mask_r[gi]; // R19 R23
         end
      end
   endgenerate

   // ****************************************
   // Alert pin
   // ****************************************
   // Open drain: output is always low, only enable moves
   logic alert_r;
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) alert_r <= 1'b0;
      else alert_r <= ctrl_r[CTRL_ALERT_OUT_PIN_EN] && (|summary); // R24 R25
   end
   assign o_alert_out_pin_o = 1'b0;
   assign o_alert_out_pin_oe = alert_r;

   // ****************************************
   // Read port
   // ****************************************
   logic [ADDR_W-1:0] l3_idx;
   logic [ADDR_W-1:0] l3_off;
   always_comb begin
      l3_idx = {2'b00, i_addr[ADDR_W-1:2]};
      l3_off = l3_idx - IDX_L3_FIRST;
   end
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         o_rdata <= '0;
         case (i_addr)
            ADDR_CTRL: o_rdata <= ctrl_r;
            ADDR_CTS_TIME: o_rdata <= cts_time_r;
            ADDR_LONG_TIMEOUT_PERIOD: o_rdata <= long_timeout_period_r;
            ADDR_SUMMARY: o_rdata <= {28'h000_0000, summary}; // R19
            ADDR_L2: o_rdata <= {24'h00_0000, l2_r};
            ADDR_MASK: o_rdata <= {28'h000_0000, mask_r};
            ADDR_UNLOCK: o_rdata <= {31'h0000_0000, debug_on_r};
            ADDR_DBG_CTRL: o_rdata <= {24'h00_0000, dbg_ctrl_r};
            ADDR_DBG_STAT: o_rdata <= {24'h00_0000, i_dbg_status}; // R17
            ADDR_TIMER_STAT:
               o_rdata <= {29'h0000_0000, cts_flag_r, mode_r};
            default: begin
               if (i_addr[1:0] == 2'b00 && l3_idx >= IDX_L3_FIRST
                   && l3_off < 16'(N_L3))
                  o_rdata <= {24'h00_0000,
                              l3_r[l3_off[2:0]*L3_W +: L3_W]}; // R18
            end
         endcase
      end
   end

   assign o_mode = mode_r;
   assign o_debug_on = debug_on_r;
   assign o_debug_ctrl = dbg_ctrl_r;
   assign o_short_timeout = cts_flag_r;
endmodule : cfs_supervisor

// ---- cfs_supervisor_asserts.sv ----
`timescale 1ns/1ps
// ********
// Port checks
// ********
module cfs_supervisor_asserts
   import cfs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic i_host_frame_ok,
   input wire logic i_chain_frame_ok,
   input wire logic [N_L3*L3_W-1:0] i_l3_cond,
   input wire logic [N_GRP-1:0] i_l2_direct,
   input wire logic [7:0] i_dbg_status,
   input wire logic [1:0] o_mode,
   input wire logic o_debug_on,
   input wire logic [7:0] o_debug_ctrl,
   input wire logic o_short_timeout,
   input wire logic o_alert_out_pin_o,
   input wire logic o_alert_out_pin_oe
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   chk_pin_data_low: assert property (!o_alert_out_pin_o)
      else $error("alert pin data not low");
   chk_rdata_stands: assert property (!$past(i_rd) |-> $stable(o_rdata))
      else $error("read data moved without read");
   chk_dbg_stat_rd: assert property (i_rd && i_addr == ADDR_DBG_STAT
      |=> o_rdata == {24'h00_0000, $past(i_dbg_status)})
      else $error("debug status read wrong");
   chk_mode_held: assert property ($past(o_mode) != CFS_ACTIVE
      && o_mode != $past(o_mode) |-> $past(i_wr) || $past(i_wr, 2))
      else $error("mode left sleep without write");
   chk_frame_restart: assert property ($rose(o_short_timeout)
      |-> !$past(i_host_frame_ok, 2) && !$past(i_chain_frame_ok, 3))
      else $error("short timeout despite recent frame");
   chk_short_active: assert property ($rose(o_short_timeout)
      |-> $past(o_mode) == CFS_ACTIVE)
      else $error("short timeout outside active");
   chk_short_latch: assert property ($fell(o_short_timeout)
      |-> $past(i_wr) || $past(i_wr, 2))
      else $error("short timeout flag not latched");
   chk_alert_latch: assert property ($fell(o_alert_out_pin_oe)
      |-> $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3))
      else $error("alert released without write");
   chk_debug_entry: assert property ($rose(o_debug_on)
      |-> $past(i_wr) && $past(i_addr) == ADDR_UNLOCK
      && $past(i_wdata[7:0]) == UNLOCK_KEY)
      else $error("debug entered without key");
   chk_debug_gate: assert property ($changed(o_debug_ctrl) && $past(i_wr)
      |-> $past(o_debug_on))
      else $error("debug control written while locked");
endmodule : cfs_supervisor_asserts

bind cfs_supervisor cfs_supervisor_asserts u_chk (.i_clk(i_clk),
   .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_host_frame_ok(i_host_frame_ok),
   .i_chain_frame_ok(i_chain_frame_ok), .i_l3_cond(i_l3_cond),
   .i_l2_direct(i_l2_direct), .i_dbg_status(i_dbg_status), .o_mode(o_mode),
   .o_debug_on(o_debug_on), .o_debug_ctrl(o_debug_ctrl),
   .o_short_timeout(o_short_timeout),
   .o_alert_out_pin_o(o_alert_out_pin_o),
   .o_alert_out_pin_oe(o_alert_out_pin_oe));

// ---- cfs_supervisor_test.sv ----
`timescale 1ns/1ps
// ********
// Bench
// ********
module cfs_supervisor_test;
   import cfs_pkg::*;
   logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, hf, cf, go = 0, oe, ao;
   logic [N_GRP-1:0] l2d = '0;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0, o_rdata, d;
   logic [N_L3*L3_W-1:0] i_l3_cond = '0;
   logic [7:0] i_dbg_status = '0, dctl;
   logic [1:0] o_mode;
   logic don, sto;
   int err_total = 0, n_tests = 0, cyc = 0, l3[N_L3], mask = 0;
   always #12.5 i_clk = ~i_clk;
   cfs_link_model u_link (.i_clk(i_clk), .i_go(go), .i_n(8'd20),
      .i_gap(4'h2), .o_host_frame_ok(hf), .o_chain_frame_ok(cf));
   cfs_supervisor dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_host_frame_ok(hf), .i_chain_frame_ok(cf), .i_l3_cond(i_l3_cond),
      .i_l2_direct(l2d), .i_dbg_status(i_dbg_status), .o_mode(o_mode),
      .o_debug_on(don), .o_debug_ctrl(dctl), .o_short_timeout(sto),
      .o_alert_out_pin_o(ao), .o_alert_out_pin_oe(oe));
   function automatic int l2_exp();
      int r = 0;
      for (int k = 0; k < N_L3; k++) if (l3[k] != 0) r |= 1 << k;
      return r;
   endfunction : l2_exp
   function automatic int sum_exp();
      int r = 0;
      int e = l2_exp();
      for (int k = 0; k < N_L2; k++)
         if (e[k] && !mask[L2_GRP[2*k+:2]]) r |= 1 << L2_GRP[2*k+:2];
      return r;
   endfunction : sum_exp
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task automatic wt(int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : wt
   task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask : rd
   // Hang guard, far above the few hundred cycles needed
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      void'($urandom(32'h535e_f5ff));
      i_dbg_status = 8'($urandom());
      repeat (16) @(posedge i_clk);
      i_rst_n <= 1'b1;
      wt(4);
      rd(ADDR_CTRL, d); chk("ctrl", d, CTRL_RST);
      rd(ADDR_CTS_TIME, d); chk("cts", d, CTS_RST);
      rd(ADDR_LONG_TIMEOUT_PERIOD, d); chk("ctl", d, CTL_RST);
      rd(16'h0030, d); chk("unmapped", d, 0);
      rd(ADDR_DBG_STAT, d); chk("dbg_stat", d, i_dbg_status);
      wr(ADDR_DBG_CTRL, 32'h0000_0011); wt(1);
      chk("dbg_locked", dctl, DBG_CTRL_RST);
      wr(ADDR_UNLOCK, UNLOCK_KEY); wr(ADDR_DBG_CTRL, 32'h0000_0011); wt(1);
      chk("dbg_on", don, 1);
      chk("dbg_ctrl", dctl, 8'h11);
      $display("register test done");
      wr(ADDR_CTRL, 32'h0000_0001);
      foreach (l3[k]) begin
         l3[k] = $urandom_range(255, 1);
         i_l3_cond[k*8+:8] <= 8'(l3[k]);
         wt(6);
         rd(16'(4 * (IDX_L3_FIRST + k)), d); chk("l3", d, l3[k]);
         rd(ADDR_L2, d); chk("l2", d, l2_exp());
         rd(ADDR_SUMMARY, d); chk("summary", d, sum_exp());
         chk("alert", oe, 1);
         chk("alert_data", ao, 0);
      end
      for (int g = 0; g <= N_GRP; g++) begin
         mask = (g < N_GRP) ? (15 ^ (1 << g)) : 15;
         wr(ADDR_MASK, mask); wt(3);
         rd(ADDR_SUMMARY, d); chk("masked_sum", d, sum_exp());
         chk("masked_alert", oe, sum_exp() != 0);
      end
      mask = 0;
      wr(ADDR_MASK, 0); wr(ADDR_RESET, 32'h0000_000F); wt(2);
      rd(ADDR_L2, d); chk("l2_persist", d, l2_exp());
      i_l3_cond[31:0] <= '0;
      wt(4);
      for (int g = 0; g < 2; g++) begin
         wr(ADDR_RESET, 1 << g); wt(2);
         l3[2*g] = 0;
         l3[2*g+1] = 0;
         rd(ADDR_L2, d); chk("l2_clear", d, l2_exp());
         rd(16'(4 * (IDX_L3_FIRST + 2 * g)), d); chk("l3_clear", d, 0);
      end
      i_l3_cond <= '0;
      l2d <= 4'h8;
      wt(4);
      rd(ADDR_L2, d); chk("l2_direct", d, l2_exp() | 32'h80);
      l2d <= 4'h0;
      wr(ADDR_RESET, 32'h0000_000F); wt(1);
      rd(ADDR_L2, d); chk("l2_all_clear", d, 0);
      $display("fault test done");
      wr(ADDR_CTS_TIME, 3); wr(ADDR_LONG_TIMEOUT_PERIOD, 40);
      go <= 1'b1;
      wt(1);
      go <= 1'b0;
      wr(ADDR_CTRL, 32'h0000_000C); wt(36);
      chk("short_held", sto, 0);
      wt(8); chk("short_set", sto, 1);
      wt(44); chk("sleep", o_mode, CFS_SLEEP);
      wr(ADDR_CTRL, 32'h0000_002E); wt(44);
      chk("shutdown", o_mode, CFS_SHUTDOWN);
      wr(ADDR_CTRL, 32'h0000_002A); wt(5);
      chk("cleared", o_mode, CFS_ACTIVE);
      $display("timer test done");
      conclude();
   end
endmodule : cfs_supervisor_test
